// >>> logic/pmw_pkg.sv
/*
  constants, register map and state type of the power mode and wake controller.
  assumes a 200 MHz core clock and a 32-bit AHB-Lite register bus.
*/
`default_nettype none
package pmw_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CORE_CLK_MHZ  = 200;
  localparam int unsigned PWR_SETTLE_NS = 2000;
  localparam int unsigned CLK_SETTLE_NS = 500;
  localparam int unsigned CNT_W         = 10;
  localparam logic [CNT_W-1:0] PWR_SETTLE_CYC =
    CNT_W'((PWR_SETTLE_NS * CORE_CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] CLK_SETTLE_CYC =
    CNT_W'((CLK_SETTLE_NS * CORE_CLK_MHZ + 999) / 1000);

  // ----------------------------------------
  // bus and register map
  // ----------------------------------------
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned HTRANS_BUSY = 1;
  localparam logic [2:0]  SIZE_WORD   = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_WAKE_EN = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_SRAM    = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_SW_RST  = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_GATE    = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_TMR_LO  = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_TMR_HI  = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_TMR_CNT = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_CAUSE   = 8'h24;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int unsigned CTRL_W        = 7;
  localparam int unsigned CTRL_GO       = 0;
  localparam int unsigned CTRL_MODE_LSB = 1;
  localparam int unsigned CTRL_RADIO_OFF = 3;
  localparam int unsigned CTRL_LP_RC    = 4;
  localparam int unsigned CTRL_MP_RC    = 5;
  localparam int unsigned CTRL_HP_EN    = 6;
  localparam logic [CTRL_W-1:0] CTRL_KEEP = 7'h78;
  localparam logic [CTRL_W-1:0] CTRL_RST  = 7'h40;
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_RET  = 2'h1;
  localparam logic [1:0] MODE_HIB  = 2'h2;
  localparam logic [1:0] MODE_SOFF = 2'h3;

  localparam int unsigned N_WAKE   = 8;
  localparam int unsigned WK_TIMER = 0;
  localparam logic [N_WAKE-1:0] WK_RET_MASK  = 8'h3F;
  localparam logic [N_WAKE-1:0] WK_SOFF_MASK = 8'hC1;

  localparam int unsigned SRAM_MACROS = 8;
  localparam int unsigned SRAM_LV_BIT = 8;
  localparam logic [SRAM_MACROS:0] SRAM_RST = 9'h0FF;
  localparam int unsigned N_MOD_RST = 8;
  localparam int unsigned N_GATE    = 8;
  localparam int unsigned N_BO      = 3;
  localparam int unsigned TMR_W     = 40;

  typedef enum logic [2:0] {
    ST_PDOWN, ST_BOOT, ST_ACTIVE, ST_ENTER, ST_LOWPWR, ST_WAKE_PWR, ST_WAKE_CLK
  } pmw_state_e;
endpackage
`default_nettype wire

// >>> logic/pmw_power_ctrl.sv
/*
  power mode, reset and wake controller with an AHB-Lite register slave.
  assumes pins and pmu status are asynchronous; bus is on core_clk_i.
*/
//
// Contract
// - low, medium and high clocks, each enabled; low and medium source selectable
// - chip reset held until the pmu reports stable supplies
// - no reset pin; power-down pin acts as the external reset
// - software register write resets individual modules
// - five primary power states with secondary sub-states
// - active powers all; clock gating and wait-for-interrupt idle reduce power
// - active sub-state with only the radio powered down
// - retention keeps flops and chosen 16 kB steps of 128 kB sram
// - outputs latched as retention or hibernation entry begins, held throughout
// - retention wakes on timer, gpio, keyboard, mouse, sensor, debug connect
// - sram supply may be lowered during retention
// - hibernation powers down memory, keeps minimal flops and io state
// - soc off unpowers digital domains; leaving it is a cold boot
// - soc off wakes only on timer, wake pin or comparator
// - pmu raises distinct brownout interrupts to the processor
// - sensor hub threshold crossing wakes the chip
// - 40-bit wake timer on low power clock sets soc off duration
`timescale 1ns/10ps
`default_nettype none
module pmw_power_ctrl
  import pmw_pkg::*;
(
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   hsel_i,
  input  wire logic [31:0]            haddr_i,
  input  wire logic [1:0]             htrans_i,
  input  wire logic                   hwrite_i,
  input  wire logic [2:0]             hsize_i,
  input  wire logic [31:0]            hwdata_i,
  input  wire logic                   hready_i,
  output logic                        hreadyout_o,
  output logic                        hresp_o,
  output logic      [31:0]            hrdata_o,
  input  wire logic                   lp_clk_i,
  input  wire logic                   power_down_pin_i,
  input  wire logic                   pmu_supply_ok_i,
  input  wire logic                   wait_for_interrupt_idle_i,
  input  wire logic [N_BO-1:0]        brownout_i,
  input  wire logic                   gpio_wake_i,
  input  wire logic                   kbd_wake_i,
  input  wire logic                   mouse_wake_i,
  input  wire logic                   sensor_wake_i,
  input  wire logic                   debug_conn_i,
  input  wire logic                   digital_wake_input_i,
  input  wire logic                   comparator_wake_input_i,
  output logic                        chip_rst_o,
  output logic                        core_rst_o,
  output logic      [N_MOD_RST-1:0]   mod_rst_o,
  output logic      [N_GATE-1:0]      clk_gate_o,
  output logic                        clk_lp_en_o,
  output logic                        clk_mp_en_o,
  output logic                        clk_hp_en_o,
  output logic                        lp_src_rc_o,
  output logic                        mp_src_rc_o,
  output logic                        cpu_idle_o,
  output logic                        radio_pwr_o,
  output logic                        digital_pwr_o,
  output logic                        pmu_on_o,
  output logic                        pmu_ulp_o,
  output logic      [SRAM_MACROS-1:0] sram_pwr_o,
  output logic                        sram_lv_o,
  output logic                        io_hold_o,
  output logic      [N_BO-1:0]        brownout_irq_o
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int unsigned N_IN = 7 + N_BO + 4;
  logic [N_IN-1:0]   pin_s;
  logic              lp_s;
  logic              pwd_s;
  logic              sup_s;
  logic              wfi_s;
  logic [N_BO-1:0]   bo_s;
  logic [N_WAKE-2:0] ext_wk_s;
  logic              lp_prev_q;

  pmw_sync #(.W(N_IN)) u_sync (
    .clk_i (core_clk_i),
    .rst_i (rst_i),
    .d_i   ({lp_clk_i, power_down_pin_i, pmu_supply_ok_i,
             wait_for_interrupt_idle_i, brownout_i,
             comparator_wake_input_i, digital_wake_input_i, debug_conn_i,
             sensor_wake_i, mouse_wake_i, kbd_wake_i, gpio_wake_i}),
    .q_o   (pin_s)
  );
  assign {lp_s, pwd_s, sup_s, wfi_s, bo_s, ext_wk_s} = pin_s;

  // low power clock is sampled, not a second domain
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lp_prev_q <= 1'b0;
    end else begin
      lp_prev_q <= lp_s;
    end
  end
  wire lp_tick = lp_s & ~lp_prev_q;

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  logic              wr_ph_q;
  logic              rd_ph_q;
  logic [ADDR_W-1:0] addr_q;
  logic [31:0]       rd_mux;

  // non-word transfers complete but do nothing
  wire ahb_take = hsel_i & hready_i & htrans_i[HTRANS_BUSY] & (hsize_i == SIZE_WORD);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_ph_q <= 1'b0;
      rd_ph_q <= 1'b0;
      addr_q  <= '0;
    end else begin
      wr_ph_q <= ahb_take & hwrite_i;
      rd_ph_q <= ahb_take & ~hwrite_i;
      if (ahb_take) begin
        addr_q <= haddr_i[ADDR_W-1:0];
      end
    end
  end

  // one wait state on reads so a write just before is seen
  assign hreadyout_o = ~rd_ph_q;
  assign hresp_o     = 1'b0;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hrdata_o <= '0;
    end else if (rd_ph_q) begin
      hrdata_o <= rd_mux;
    end
  end

  wire we_ctrl  = wr_ph_q & (addr_q == ADDR_CTRL);
  wire we_wake  = wr_ph_q & (addr_q == ADDR_WAKE_EN);
  wire we_sram  = wr_ph_q & (addr_q == ADDR_SRAM);
  wire we_rst   = wr_ph_q & (addr_q == ADDR_SW_RST);
  wire we_gate  = wr_ph_q & (addr_q == ADDR_GATE);
  wire we_tlo   = wr_ph_q & (addr_q == ADDR_TMR_LO);
  wire we_thi   = wr_ph_q & (addr_q == ADDR_TMR_HI);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  pmw_state_e          state_q;
  pmw_state_e          state_d;
  logic [CTRL_W-1:0]   ctrl_q;
  logic [N_WAKE-1:0]   wake_en_q;
  logic [N_WAKE-1:0]   wk_snap_q;
  logic [N_WAKE-1:0]   cause_q;
  logic [SRAM_MACROS:0] sram_q;
  logic [N_GATE-1:0]   gate_q;
  logic [TMR_W-1:0]    tload_q;
  logic [TMR_W-1:0]    tcount;
  logic                tmr_exp;
  logic [1:0]          mode_q;
  logic [CNT_W-1:0]    cnt_q;

  wire go       = we_ctrl & hwdata_i[CTRL_GO];
  wire [1:0] req_mode = hwdata_i[CTRL_MODE_LSB +: 2];
  wire enter    = (state_q == ST_ACTIVE) & go & (req_mode != MODE_NONE);
  wire [1:0] mode_d = enter ? req_mode : mode_q;
  wire boot_entry = (state_d == ST_BOOT) & (state_q != ST_BOOT);

  // cold start returns configuration to defaults
  always_ff @(posedge core_clk_i) begin
    if (rst_i || boot_entry) begin
      ctrl_q    <= CTRL_RST;
      wake_en_q <= '0;
      sram_q    <= SRAM_RST;
      gate_q    <= '0;
      tload_q   <= '0;
    end else begin
      if (we_ctrl) ctrl_q <= hwdata_i[CTRL_W-1:0] & CTRL_KEEP;
      if (we_wake) wake_en_q <= hwdata_i[N_WAKE-1:0];
      if (we_sram) sram_q <= hwdata_i[SRAM_MACROS:0];
      if (we_gate) gate_q <= hwdata_i[N_GATE-1:0];
      if (we_tlo) tload_q[31:0] <= hwdata_i;
      if (we_thi) tload_q[TMR_W-1:32] <= hwdata_i[TMR_W-33:0];
    end
  end

  // per-module reset pulse, independent of chip reset
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mod_rst_o <= '0;
    end else begin
      mod_rst_o <= we_rst ? hwdata_i[N_MOD_RST-1:0] : '0;
    end
  end

  assign rd_mux =
    (addr_q == ADDR_CTRL)    ? {25'h000_0000, ctrl_q} :
    (addr_q == ADDR_STATUS)  ? {24'h00_0000, bo_s, sup_s, wfi_s, state_q} :
    (addr_q == ADDR_WAKE_EN) ? {24'h00_0000, wake_en_q} :
    (addr_q == ADDR_SRAM)    ? {23'h00_0000, sram_q} :
    (addr_q == ADDR_GATE)    ? {24'h00_0000, gate_q} :
    (addr_q == ADDR_TMR_LO)  ? tload_q[31:0] :
    (addr_q == ADDR_TMR_HI)  ? {24'h00_0000, tload_q[TMR_W-1:32]} :
    (addr_q == ADDR_TMR_CNT) ? tcount[31:0] :
    (addr_q == ADDR_CAUSE)   ? {24'h00_0000, cause_q} :
    32'h0000_0000;

  // ----------------------------------------
  // wake sources
  // ----------------------------------------
  wire [N_WAKE-1:0] wk_src  = {ext_wk_s, tmr_exp};
  wire [N_WAKE-1:0] wk_mask = (mode_q == MODE_SOFF) ? WK_SOFF_MASK : WK_RET_MASK;
  wire [N_WAKE-1:0] wk_hits = wk_src & wk_snap_q & wk_mask;
  wire wake_hit = (state_q == ST_LOWPWR) & (|wk_hits);

  pmw_wake_timer u_timer (
    .clk_i      (core_clk_i),
    .rst_i      (rst_i),
    .tick_i     (lp_tick),
    .load_i     (state_q == ST_ENTER),
    .run_i      ((state_q == ST_LOWPWR) & wk_snap_q[WK_TIMER]),
    .load_val_i (tload_q),
    .count_o    (tcount),
    .expired_o  (tmr_exp)
  );

  // enables are frozen at entry; later writes wait for the next entry
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wk_snap_q <= '0;
      cause_q   <= '0;
      mode_q    <= MODE_NONE;
    end else begin
      mode_q <= mode_d;
      if (state_q == ST_ENTER) begin
        wk_snap_q <= wake_en_q;
        cause_q   <= '0;
      end else if (wake_hit) begin
        cause_q <= wk_hits;
      end
    end
  end

  // ----------------------------------------
  // power state machine
  // ----------------------------------------
  wire [CNT_W-1:0] settle_cyc = (state_q == ST_WAKE_PWR) ? PWR_SETTLE_CYC : CLK_SETTLE_CYC;
  wire settled = (cnt_q == settle_cyc);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_PDOWN: begin
        if (!pwd_s) state_d = ST_BOOT;
      end
      ST_BOOT: begin
        if (sup_s) state_d = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (enter) state_d = ST_ENTER;
      end
      ST_ENTER: begin
        state_d = ST_LOWPWR;
      end
      ST_LOWPWR: begin
        if (wake_hit) begin
          state_d = (mode_q == MODE_SOFF) ? ST_BOOT : ST_WAKE_PWR;
        end
      end
      ST_WAKE_PWR: begin
        if (settled) state_d = ST_WAKE_CLK;
      end
      ST_WAKE_CLK: begin
        if (settled) state_d = ST_ACTIVE;
      end
      default: begin
        state_d = ST_BOOT;
      end
    endcase
    if (pwd_s) state_d = ST_PDOWN;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= ST_BOOT;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= (state_d != state_q) ? '0 : cnt_q + CNT_W'(1);
    end
  end

  // ----------------------------------------
  // power, clock and reset outputs
  // ----------------------------------------
  wire pd_d   = (state_d == ST_PDOWN);
  wire boot_d = (state_d == ST_BOOT);
  wire act_d  = (state_d == ST_ACTIVE);
  wire low_d  = (state_d == ST_LOWPWR);
  wire held_d = (state_d == ST_ENTER) | low_d;
  wire wake_d = (state_d == ST_WAKE_PWR) | (state_d == ST_WAKE_CLK);
  wire ret_d  = (mode_d == MODE_RET);
  wire hib_d  = (mode_d == MODE_HIB);
  wire soff_d = (mode_d == MODE_SOFF);
  wire mp_d   = act_d | (state_d == ST_ENTER) | (state_d == ST_WAKE_CLK);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      chip_rst_o     <= 1'b1;
      core_rst_o     <= 1'b1;
      digital_pwr_o  <= 1'b0;
      pmu_on_o       <= 1'b1;
      pmu_ulp_o      <= 1'b0;
      clk_lp_en_o    <= 1'b0;
      clk_mp_en_o    <= 1'b0;
      clk_hp_en_o    <= 1'b0;
      lp_src_rc_o    <= 1'b0;
      mp_src_rc_o    <= 1'b0;
      cpu_idle_o     <= 1'b0;
      radio_pwr_o    <= 1'b0;
      sram_pwr_o     <= '0;
      sram_lv_o      <= 1'b0;
      io_hold_o      <= 1'b0;
      clk_gate_o     <= '0;
      brownout_irq_o <= '0;
    end else begin
      chip_rst_o    <= pd_d | boot_d | (low_d & soff_d);
      core_rst_o    <= pd_d | boot_d | (low_d & (soff_d | hib_d))
                       | (wake_d & hib_d);
      digital_pwr_o <= ~pd_d & ~(low_d & (hib_d | soff_d));
      pmu_on_o      <= ~pd_d;
      pmu_ulp_o     <= low_d & soff_d;
      clk_lp_en_o   <= ~pd_d;
      clk_mp_en_o   <= mp_d;
      clk_hp_en_o   <= mp_d & ctrl_q[CTRL_HP_EN];
      lp_src_rc_o   <= ctrl_q[CTRL_LP_RC];
      mp_src_rc_o   <= ctrl_q[CTRL_MP_RC];
      cpu_idle_o    <= act_d & wfi_s;
      radio_pwr_o   <= act_d & ~ctrl_q[CTRL_RADIO_OFF];
      // only retention keeps a chosen subset of macros
      sram_pwr_o    <= pd_d ? '0 :
                       low_d ? (ret_d ? sram_q[SRAM_MACROS-1:0] : '0) : '1;
      sram_lv_o     <= low_d & ret_d & sram_q[SRAM_LV_BIT];
      io_hold_o     <= (held_d | wake_d) & (ret_d | hib_d);
      clk_gate_o    <= act_d ? gate_q : '1;
      brownout_irq_o <= bo_s;
    end
  end
endmodule
`default_nettype wire

// >>> logic/pmw_sync.sv
/*
  three-flop synchroniser; an output bit changes once flops two and three agree.
  assumes inputs asynchronous to core_clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module pmw_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ----------------------------------------
  // agreement filter, per bit
  // ----------------------------------------
  // one process owns q_o; per-bit processes would drive one vector twice
  wire [W-1:0] q_d;
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign q_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : q_o[i];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= '0;
    end else begin
      q_o <= q_d;
    end
  end
endmodule
`default_nettype wire

// >>> logic/pmw_wake_timer.sv
/*
  40-bit down counting wake timer advanced by low power clock ticks.
  assumes tick_i is a one-cycle pulse per rising low power clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module pmw_wake_timer
  import pmw_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             tick_i,
  input  wire logic             load_i,
  input  wire logic             run_i,
  input  wire logic [TMR_W-1:0] load_val_i,
  output logic      [TMR_W-1:0] count_o,
  output logic                  expired_o
);
  wire cnt_zero = (count_o == '0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= '0;
    end else if (load_i) begin
      count_o <= load_val_i;
    end else if (run_i && tick_i && !cnt_zero) begin
      count_o <= count_o - TMR_W'(1);
    end
  end

  // a zero load expires one cycle after the run starts, as expired_o is registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      expired_o <= 1'b0;
    end else begin
      expired_o <= run_i && !load_i && cnt_zero;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/pmw_power_ctrl_asserts.sv
/*
  port checker for the power mode and wake controller.
  assumes it is bound onto pmw_power_ctrl; one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module pmw_power_ctrl_asserts
  import pmw_pkg::*;
(
  input wire logic            core_clk_i,
  input wire logic            rst_i,
  input wire logic            power_down_pin_i,
  input wire logic            pmu_supply_ok_i,
  input wire logic [N_BO-1:0] brownout_i,
  input wire logic [N_BO-1:0] brownout_irq_o,
  input wire logic            chip_rst_o,
  input wire logic            core_rst_o,
  input wire logic [7:0]      mod_rst_o,
  input wire logic            io_hold_o,
  input wire logic            digital_pwr_o,
  input wire logic            pmu_on_o,
  input wire logic            pmu_ulp_o,
  input wire logic            clk_mp_en_o,
  input wire logic            sram_lv_o,
  input wire logic            cpu_idle_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_rst_after_ok: assert property (
    $fell(chip_rst_o) |-> $past(pmu_supply_ok_i, 3)) else $error("reset left before supply ok");
  a_pin_powers_off: assert property (
    power_down_pin_i [*8] |-> chip_rst_o && !pmu_on_o && !digital_pwr_o)
    else $error("power-down pin not obeyed");
  a_mod_rst_pulse: assert property (
    |mod_rst_o |=> mod_rst_o == 8'h00) else $error("module reset longer than one cycle");
  a_idle_active: assert property (
    cpu_idle_o |-> !chip_rst_o && digital_pwr_o && !io_hold_o) else $error("idle outside active");
  a_hold_stays: assert property (
    $rose(io_hold_o) |=> io_hold_o [*8]) else $error("pad hold dropped early");
  a_lv_in_lowpwr: assert property (
    sram_lv_o |-> io_hold_o) else $error("sram low voltage outside retention");
  a_soff_ulp: assert property (
    pmu_ulp_o |-> pmu_on_o && !digital_pwr_o) else $error("soc off powers wrong");
  a_bo_follow: assert property (
    $stable(brownout_i) [*6] |-> brownout_irq_o == brownout_i) else $error("brownout not passed on");
  a_clk_then_act: assert property (
    $rose(clk_mp_en_o) && io_hold_o |-> ##[95:105] $fell(io_hold_o))
    else $error("wake clock phase length wrong");
  a_wake_active: assert property (
    $fell(io_hold_o) |-> !core_rst_o && !chip_rst_o && digital_pwr_o)
    else $error("hold released before active");
  c_wake: cover property ($fell(io_hold_o));
  c_cold: cover property ($fell(pmu_ulp_o));
  c_modrst: cover property (|mod_rst_o);
endmodule
`default_nettype wire

// >>> testbench/pmw_wake_partner.sv
/*
  far side: low power clock, power-down pin, supply status and wake sources.
  assumes a 200 MHz core_clk_i; lines change just after its rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module pmw_wake_partner (
  input  wire logic       core_clk_i,
  output var  logic       lp_clk_o,
  output var  logic       pd_pin_o,
  output var  logic       supply_ok_o,
  output var  logic [6:0] wake_o
);
  // ----------------------------------------
  // lines
  // ----------------------------------------
  initial begin
    lp_clk_o = 1'b0;
    pd_pin_o = 1'b0;
    supply_ok_o = 1'b0;
    wake_o = 7'h00;
    // crystal clock runs free, also in low power
    forever #15258.79 lp_clk_o = ~lp_clk_o;
  end
  task automatic set_lines(input logic pd, input logic ok, input logic [6:0] wk);
    @(posedge core_clk_i);
    pd_pin_o <= pd;
    supply_ok_o <= ok & ~pd;
    wake_o <= wk;
  endtask
endmodule
`default_nettype wire

// >>> testbench/power_mode_wake_controller_tb_top.sv
/*
  self-checking bench for pmw_power_ctrl with the far-side model and checker.
  assumes the one AHB-Lite slave drives hready; 200 MHz core clock.
*/
`timescale 1ns/10ps
`default_nettype none
module power_mode_wake_controller_tb_top
  import pmw_pkg::*;
;
  logic core_clk_i, rst_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
  logic [1:0]  htrans_i;
  logic [2:0]  hsize_i, brownout_i, brownout_irq_o;
  logic lp_clk_i, power_down_pin_i, pmu_supply_ok_i, wait_for_interrupt_idle_i;
  logic chip_rst_o, core_rst_o, clk_lp_en_o, clk_mp_en_o, clk_hp_en_o, lp_src_rc_o;
  logic mp_src_rc_o, cpu_idle_o, radio_pwr_o, digital_pwr_o, pmu_on_o, pmu_ulp_o;
  logic sram_lv_o, io_hold_o;
  logic [7:0] mod_rst_o, clk_gate_o, sram_pwr_o, m;
  logic [6:0] wk;
  int errors, n_compared, i, k;
  logic [7:0]  ra [8] = '{ADDR_WAKE_EN, ADDR_SRAM, ADDR_GATE, ADDR_TMR_LO,
                          ADDR_TMR_HI, ADDR_SW_RST, 8'h3C, ADDR_STATUS};
  logic [31:0] rw [8] = '{32'h0000_00FF, 32'h0000_01FF, 32'h0000_00A5, 32'h1234_5678,
                          32'hFFFF_FFFF, 32'h0000_0001, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
  logic [31:0] re [8] = '{32'h0000_00FF, 32'h0000_01FF, 32'h0000_00A5, 32'h1234_5678,
                          32'h0000_00FF, 32'h0000_0000, 32'h0000_0000, 32'h0000_0012};
  assign hready_i = hreadyout_o;
  pmw_power_ctrl i_dut (.core_clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i, .hwdata_i, .hready_i, .hreadyout_o, .hresp_o, .hrdata_o, .lp_clk_i,
    .power_down_pin_i, .pmu_supply_ok_i, .wait_for_interrupt_idle_i, .brownout_i,
    .gpio_wake_i(wk[0]), .kbd_wake_i(wk[1]), .mouse_wake_i(wk[2]), .sensor_wake_i(wk[3]),
    .debug_conn_i(wk[4]), .digital_wake_input_i(wk[5]), .comparator_wake_input_i(wk[6]),
    .chip_rst_o, .core_rst_o, .mod_rst_o, .clk_gate_o, .clk_lp_en_o, .clk_mp_en_o,
    .clk_hp_en_o, .lp_src_rc_o, .mp_src_rc_o, .cpu_idle_o, .radio_pwr_o, .digital_pwr_o,
    .pmu_on_o, .pmu_ulp_o, .sram_pwr_o, .sram_lv_o, .io_hold_o, .brownout_irq_o);
  pmw_wake_partner i_far (.core_clk_i, .lp_clk_o(lp_clk_i), .pd_pin_o(power_down_pin_i),
    .supply_ok_o(pmu_supply_ok_i), .wake_o(wk));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_of_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i <= {24'h0, a};
    do @(posedge core_clk_i); while (hready_i !== 1'b1);
    htrans_i <= 2'h0;
    hsel_i <= 1'b0;
    hwdata_i <= wd;
    do @(posedge core_clk_i); while (hready_i !== 1'b1);
    rd = hrdata_o;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("read", rd, e);
  endtask
  task lp(input logic [31:0] en, input logic [31:0] sr, input logic [31:0] ct);
    bus(1'b1, ADDR_WAKE_EN, en);
    bus(1'b1, ADDR_SRAM, sr);
    bus(1'b1, ADDR_CTRL, ct);
    repeat (4) @(negedge core_clk_i);
  endtask
  task pulse(input logic [6:0] w);
    i_far.set_lines(1'b0, 1'b1, w);
    repeat (30) @(posedge core_clk_i);
    i_far.set_lines(1'b0, 1'b1, 7'h00);
  endtask
  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  initial begin
    #450000;
    errors++;
    end_of_test();
  end
  initial begin
    {rst_i, hsel_i, haddr_i, htrans_i, hwrite_i, hwdata_i} = {1'b1, 68'h0};
    {hsize_i, wait_for_interrupt_idle_i, brownout_i} = {3'h2, 4'h0};
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (10) @(negedge core_clk_i);
    chk("chip_rst", chip_rst_o, 1'b1);
    i_far.set_lines(1'b0, 1'b1, 7'h00);
    for (i = 0; i < 50 && chip_rst_o !== 1'b0; i++) @(negedge core_clk_i);
    chk("chip_rst", chip_rst_o, 1'b0);
    rchk(ADDR_CTRL, 32'h0000_0040);
    rchk(ADDR_SRAM, 32'h0000_00FF);
    rchk(ADDR_WAKE_EN, 32'h0);
    for (i = 0; i < 8; i++) begin
      bus(1'b1, ra[i], rw[i]);
      rchk(ra[i], re[i]);
    end
    chk("clk_gate", clk_gate_o, 8'hA5);
    bus(1'b1, ADDR_SW_RST, 32'h0000_0024);
    m = 8'h00;
    repeat (3) @(negedge core_clk_i) m = m | mod_rst_o;
    chk("mod_rst", m, 8'h24);
    bus(1'b1, ADDR_CTRL, 32'h0000_0078);
    repeat (3) @(negedge core_clk_i);
    chk("radio", {radio_pwr_o, digital_pwr_o}, 2'b01);
    chk("clocks", {lp_src_rc_o, mp_src_rc_o, clk_hp_en_o, clk_lp_en_o, hresp_o}, 5'h1E);
    @(posedge core_clk_i) {wait_for_interrupt_idle_i, brownout_i} <= 4'hD;
    repeat (8) @(negedge core_clk_i);
    chk("idle", cpu_idle_o, 1'b1);
    chk("brownout", brownout_irq_o, 3'h5);
    @(posedge core_clk_i) {wait_for_interrupt_idle_i, brownout_i} <= 4'h0;
    bus(1'b1, ADDR_CTRL, 32'h0000_0040);
    for (k = 0; k < 5; k++) begin
      lp(32'h2 << k, 32'h103, 32'h43);
      chk("ret", {io_hold_o, sram_lv_o, sram_pwr_o}, 10'h303);
      pulse(7'h1 << ((k + 1) % 5));
      chk("hold", io_hold_o, 1'b1);
      pulse(7'h1 << k);
      for (i = 0; i < 800 && io_hold_o !== 1'b0; i++) @(negedge core_clk_i);
      chk("wake", {io_hold_o, core_rst_o}, 2'b00);
      rchk(ADDR_CAUSE, 32'h2 << k);
    end
    lp(32'h10, 32'hFF, 32'h45);
    chk("hib", {io_hold_o, sram_pwr_o}, 9'h100);
    pulse(7'h08);
    for (i = 0; i < 800 && io_hold_o !== 1'b0; i++) @(negedge core_clk_i);
    chk("hib wake", io_hold_o, 1'b0);
    bus(1'b1, ADDR_TMR_LO, 32'h2);
    bus(1'b1, ADDR_TMR_HI, 32'h0);
    for (k = 0; k < 3; k++) begin
      lp((k == 0) ? 32'h01 : 32'h20 << k, 32'hFF, 32'h47);
      chk("soff", {pmu_ulp_o, digital_pwr_o}, 2'b10);
      pulse(7'h01);
      if (k > 0) chk("soff hold", pmu_ulp_o, 1'b1);
      if (k > 0) pulse(7'h10 << k);
      for (i = 0; i < 26000 && chip_rst_o !== 1'b0; i++) @(negedge core_clk_i);
      chk("cold", pmu_ulp_o, 1'b0);
      rchk(ADDR_CTRL, 32'h0000_0040);
      rchk(ADDR_CAUSE, (k == 0) ? 32'h01 : 32'h20 << k);
    end
    i_far.set_lines(1'b1, 1'b0, 7'h00);
    repeat (20000) @(posedge core_clk_i);
    chk("pdown", {chip_rst_o, pmu_on_o}, 2'b10);
    i_far.set_lines(1'b0, 1'b0, 7'h00);
    repeat (30) @(negedge core_clk_i);
    chk("no supply", chip_rst_o, 1'b1);
    i_far.set_lines(1'b0, 1'b1, 7'h00);
    for (i = 0; i < 100 && chip_rst_o !== 1'b0; i++) @(negedge core_clk_i);
    rchk(ADDR_CTRL, 32'h0000_0040);
    end_of_test();
  end
endmodule
bind pmw_power_ctrl pmw_power_ctrl_asserts i_chk (.core_clk_i, .rst_i, .power_down_pin_i,
  .pmu_supply_ok_i, .brownout_i, .brownout_irq_o, .chip_rst_o, .core_rst_o, .mod_rst_o,
  .io_hold_o, .digital_pwr_o, .pmu_on_o, .pmu_ulp_o, .clk_mp_en_o, .sram_lv_o, .cpu_idle_o);
`default_nettype wire
